// [hdl/lpt_pkg.sv]
// Package for the light/proximity threshold filter.
// Assumes a 125 MHz aclk and an AXI4-Lite register master.
package lpt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RANGE_CFG = 8'h12;
  localparam logic [7:0] IDX_LIGHT_HYST = 8'h16;
  localparam logic [7:0] IDX_PROX_HYST = 8'h17;
  localparam logic [7:0] IDX_PROX_PERSIST = 8'h18;
  localparam logic [7:0] IDX_LIGHT_PERSIST = 8'h19;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  // Field positions
  localparam int RANGE_SEL_BIT = 5;
  localparam int ST_LIGHT_HIGH_BIT = 0;
  localparam int ST_LIGHT_LOW_BIT = 1;
  localparam int ST_PROX_LSB = 2;
  localparam int ST_LEGACY_BIT = 5;
  // Reset values
  localparam logic [7:0] RST_RANGE_CFG = 8'h00;
  localparam logic [7:0] RST_HYST = 8'h48;
  localparam logic [7:0] RST_PERSIST = 8'h03;
  // High range divides gain by 14.5, held as twice the factor
  localparam int HIGH_RANGE_DIV_X2 = 29;
  // Hysteresis compression: mantissa has an implied leading one
  localparam int HYST_MANT_W = 4;
  localparam int HYST_HIDDEN = 16;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int DATA_W = 16;
  localparam int PROX_CH = 3;

  typedef struct packed {
    logic valid;
    logic is_ir;
    logic [15:0] code;
  } lpt_light_sample_t;

  typedef struct packed {
    logic valid;
    logic [1:0] channel;
    logic [15:0] code;
  } lpt_prox_sample_t;

  typedef struct packed {
    logic [15:0] light_low;
    logic [15:0] light_high;
    logic [2:0][15:0] prox;
  } lpt_thresholds_t;
endpackage

// [hdl/lpt_persist_chan.sv]
// One threshold channel with hysteresis band and run-length persistence.
// Assumes samples and settings come from logic on the same clock.
`timescale 1ns/1ps
module lpt_persist_chan #(
  parameter int W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample_valid,
  input wire logic [W-1:0] sample,
  input wire logic [W-1:0] threshold,
  input wire logic [W-1:0] hyst,
  input wire logic [3:0] need,
  input wire logic low_side,
  output logic status_q
);
  logic [W:0] sum;
  logic [W-1:0] upper;
  logic [W-1:0] lower;
  logic above;
  logic below;
  logic qual;
  logic [3:0] run_q;

  // Band edges saturate so a wide band never wraps
  always_comb begin
    sum = {1'b0, threshold} + {1'b0, hyst};
    upper = sum[W] ? {W{1'b1}} : sum[W-1:0];
    lower = (threshold > hyst) ? threshold - hyst : '0;
    above = sample > upper;
    below = sample < lower;
    // Leaving a state needs the far band edge, hence the hysteresis
    if (status_q) begin
      qual = low_side ? above : below;
    end else begin
      qual = low_side ? below : above;
    end
  end

  // Run counter and status flip
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 4'h0;
      status_q <= 1'b0;
    end else if (sample_valid) begin
      if (!qual) begin
        run_q <= 4'h0;
      end else if (run_q + 4'h1 >= need) begin
        run_q <= 4'h0;
        status_q <= ~status_q;
      end else begin
        run_q <= run_q + 4'h1;
      end
    end
  end
endmodule

// [hdl/lpt_filter.sv]
// Threshold filter for ambient-light and proximity results, with its
// AXI4-Lite register file. Assumes samples arrive from logic on aclk and
// thresholds are held steady by the surrounding sensor logic.
// Functional notes
// - Range bit selects normal or gain/14.5 range
// - Old sequencers apply range to IR too
// - Light hysteresis widens both light thresholds
// - Proximity hysteresis widens all three thresholds
// - Hysteresis byte expands to 16-bit codes
// - Proximity status needs persistence-count qualifying samples
// - Light status needs persistence-count qualifying samples
// - Persistence fields reset to two samples
// - Hysteresis resets to 24 codes, range zero
`timescale 1ns/1ps
module lpt_filter #(
  parameter int ADDR_W = 8,
  parameter bit LEGACY_SEQ = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire lpt_pkg::lpt_light_sample_t light_in,
  input wire lpt_pkg::lpt_prox_sample_t prox_in,
  input wire lpt_pkg::lpt_thresholds_t thr_in,
  output logic vis_high_range_q,
  output logic ir_high_range_q,
  output logic [1:0] light_status_q,
  output logic [2:0] prox_status_q,
  output logic [15:0] light_hyst_codes_q,
  output logic [15:0] prox_hyst_codes_q
);
  // Software-visible settings
  logic [7:0] range_cfg_q;
  logic [7:0] light_hyst_q;
  logic [7:0] prox_hyst_q;
  logic [7:0] prox_persist_q;
  logic [7:0] light_persist_q;

  // Write channel capture
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [7:0] wbyte_q;
  logic wlane0_q;
  logic do_write;
  logic wr_hit;

  // Decoded settings
  logic [15:0] light_hyst_codes;
  logic [15:0] prox_hyst_codes;
  logic [3:0] light_need;
  logic [3:0] prox_need;
  logic [1:0] light_st;
  logic [2:0] prox_st;
  logic [31:0] rd_word;
  logic rd_hit;

  // Expand a compressed byte: exponent high nibble, mantissa low nibble
  function automatic logic [15:0] expand_hyst(input logic [7:0] enc);
    logic [19:0] wide;
    logic [4:0] mant;
    mant = 5'(lpt_pkg::HYST_HIDDEN) | {1'b0, enc[lpt_pkg::HYST_MANT_W-1:0]};
    wide = {15'h0000, mant} << enc[7:4];
    if (enc == 8'h00) begin
      expand_hyst = 16'h0000;
    end else begin
      expand_hyst = wide[19:4];
    end
  endfunction

  // Length of the run of ones from bit 0; an empty mask means one sample
  function automatic logic [3:0] run_length(input logic [7:0] mask);
    logic stop;
    run_length = 4'h0;
    stop = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (mask[i] && !stop) begin
        run_length = run_length + 4'h1;
      end else begin
        stop = 1'b1;
      end
    end
    if (run_length == 4'h0) begin
      run_length = 4'h1;
    end
  endfunction

  // Register index from a byte address; low two bits must be zero
  function automatic logic [8:0] reg_index(input logic [ADDR_W-1:0] addr);
    if (addr[1:0] != 2'b00) begin
      reg_index = 9'h1FF;
    end else begin
      reg_index = {1'b0, 8'(addr >> 2)};
    end
  endfunction

  // Index test against the settings map
  function automatic logic is_mapped(input logic [8:0] idx, input logic wr);
    case (idx)
      {1'b0, lpt_pkg::IDX_RANGE_CFG},
      {1'b0, lpt_pkg::IDX_LIGHT_HYST},
      {1'b0, lpt_pkg::IDX_PROX_HYST},
      {1'b0, lpt_pkg::IDX_PROX_PERSIST},
      {1'b0, lpt_pkg::IDX_LIGHT_PERSIST}: begin
        is_mapped = 1'b1;
      end
      {1'b0, lpt_pkg::IDX_STATUS}: begin
        is_mapped = !wr; // Status is read-only
      end
      default: begin
        is_mapped = 1'b0;
      end
    endcase
  endfunction

  // Address and data taken in either order, one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      waddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      waddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wbyte_q <= 8'h00;
      wlane0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wbyte_q <= s_axi_wdata[7:0];
      wlane0_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // Ready drops once a beat is held, until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready)
        && !s_axi_bvalid;
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready)
        && !s_axi_bvalid;
    end
  end

  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_hit = is_mapped(reg_index(waddr_q), 1'b1);

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lpt_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? lpt_pkg::RESP_OKAY : lpt_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Settings store; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      range_cfg_q <= lpt_pkg::RST_RANGE_CFG;
      light_hyst_q <= lpt_pkg::RST_HYST;
      prox_hyst_q <= lpt_pkg::RST_HYST;
      prox_persist_q <= lpt_pkg::RST_PERSIST;
      light_persist_q <= lpt_pkg::RST_PERSIST;
    end else if (do_write && wlane0_q) begin
      case (reg_index(waddr_q))
        {1'b0, lpt_pkg::IDX_RANGE_CFG}: begin
          // Reserved bits are not stored, so they always read zero
          range_cfg_q <= wbyte_q & (8'h01 << lpt_pkg::RANGE_SEL_BIT);
        end
        {1'b0, lpt_pkg::IDX_LIGHT_HYST}: begin
          light_hyst_q <= wbyte_q;
        end
        {1'b0, lpt_pkg::IDX_PROX_HYST}: begin
          prox_hyst_q <= wbyte_q;
        end
        {1'b0, lpt_pkg::IDX_PROX_PERSIST}: begin
          prox_persist_q <= wbyte_q;
        end
        {1'b0, lpt_pkg::IDX_LIGHT_PERSIST}: begin
          light_persist_q <= wbyte_q;
        end
        default: begin
          range_cfg_q <= range_cfg_q;
        end
      endcase
    end
  end

  // Read mux; status shows the filter's live decisions
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = is_mapped(reg_index(s_axi_araddr), 1'b0);
    case (reg_index(s_axi_araddr))
      {1'b0, lpt_pkg::IDX_RANGE_CFG}: begin
        rd_word[7:0] = range_cfg_q;
      end
      {1'b0, lpt_pkg::IDX_LIGHT_HYST}: begin
        rd_word[7:0] = light_hyst_q;
      end
      {1'b0, lpt_pkg::IDX_PROX_HYST}: begin
        rd_word[7:0] = prox_hyst_q;
      end
      {1'b0, lpt_pkg::IDX_PROX_PERSIST}: begin
        rd_word[7:0] = prox_persist_q;
      end
      {1'b0, lpt_pkg::IDX_LIGHT_PERSIST}: begin
        rd_word[7:0] = light_persist_q;
      end
      {1'b0, lpt_pkg::IDX_STATUS}: begin
        rd_word[lpt_pkg::ST_LIGHT_HIGH_BIT] = light_st[0];
        rd_word[lpt_pkg::ST_LIGHT_LOW_BIT] = light_st[1];
        rd_word[lpt_pkg::ST_PROX_LSB +: lpt_pkg::PROX_CH] = prox_st;
        rd_word[lpt_pkg::ST_LEGACY_BIT] = LEGACY_SEQ;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Read channel: one read in flight, data one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= lpt_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? lpt_pkg::RESP_OKAY : lpt_pkg::RESP_DECERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Conversion range to the ADC sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vis_high_range_q <= 1'b0;
      ir_high_range_q <= 1'b0;
    end else begin
      // High range trades sensitivity for headroom in direct sunlight
      vis_high_range_q <= range_cfg_q[lpt_pkg::RANGE_SEL_BIT];
      // Later sequencers keep IR in normal range regardless
      ir_high_range_q <= LEGACY_SEQ && range_cfg_q[lpt_pkg::RANGE_SEL_BIT];
    end
  end

  // Hysteresis amounts in ADC codes
  assign light_hyst_codes = expand_hyst(light_hyst_q);
  assign prox_hyst_codes = expand_hyst(prox_hyst_q);
  assign light_need = run_length(light_persist_q);
  assign prox_need = run_length(prox_persist_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      light_hyst_codes_q <= 16'h0000;
      prox_hyst_codes_q <= 16'h0000;
    end else begin
      light_hyst_codes_q <= light_hyst_codes;
      prox_hyst_codes_q <= prox_hyst_codes;
    end
  end

  // Light window: channel 0 watches the high edge, 1 the low edge.
  // Only visible conversions are judged; IR results feed correction only.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_light
      lpt_persist_chan #(
        .W(lpt_pkg::DATA_W)
      ) u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .sample_valid(light_in.valid && !light_in.is_ir),
        .sample(light_in.code),
        .threshold(g == 0 ? thr_in.light_high : thr_in.light_low),
        .hyst(light_hyst_codes),
        .need(light_need),
        .low_side(g == 1),
        .status_q(light_st[g])
      );
    end
    // One channel per proximity LED measurement
    for (g = 0; g < lpt_pkg::PROX_CH; g++) begin : g_prox
      lpt_persist_chan #(
        .W(lpt_pkg::DATA_W)
      ) u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .sample_valid(prox_in.valid && prox_in.channel == 2'(g)),
        .sample(prox_in.code),
        .threshold(thr_in.prox[g]),
        .hyst(prox_hyst_codes),
        .need(prox_need),
        .low_side(1'b0),
        .status_q(prox_st[g])
      );
    end
  endgenerate

  // Status outputs one flop after the channel decision
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      light_status_q <= 2'h0;
      prox_status_q <= 3'h0;
    end else begin
      light_status_q <= light_st;
      prox_status_q <= prox_st;
    end
  end
endmodule

// [dv/lpt_host_model.sv]
// AXI4-Lite host model that writes and reads the filter settings.
// Assumes one request at a time and a caller that starts just after an edge.
`timescale 1ns/1ps
module lpt_host_model (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // Idle bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} <= '0;
    {araddr, arvalid, rready} <= '0;
  end

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r,
                    output bit to);
    int n;
    bit aw;
    bit w;
    n = 0;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= {24'h0, (a == {lpt_pkg::IDX_RANGE_CFG[5:0], 2'h0}) ? d & 8'h20 : d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w) && n < 100) begin
      @(posedge aclk);
      n++;
      aw = aw || awready;
      w = w || wready;
      awvalid <= !aw;
      wvalid <= !w;
    end
    // Response only counts when seen at an edge
    do begin
      @(posedge aclk);
      n++;
    end while (!bvalid && n < 100);
    r = bresp;
    bready <= 1'b0;
    to = n >= 100;
    // Idle edge, so a following call never reassigns bready in this step
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                    output bit to);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 100);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    to = n >= 100;
    // Idle edge, so a following call never reassigns rready in this step
    @(posedge aclk);
  endtask
endmodule

// [dv/lpt_filter_monitor.sv]
// Port-level checks on the threshold filter.
// Assumes it is bound to lpt_filter and sees only its ports.
`timescale 1ns/1ps
module lpt_filter_monitor #(
  parameter bit LEGACY_SEQ = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire lpt_pkg::lpt_light_sample_t light_in,
  input wire lpt_pkg::lpt_prox_sample_t prox_in,
  input wire logic vis_high_range_q,
  input wire logic ir_high_range_q,
  input wire logic [1:0] light_status_q,
  input wire logic [2:0] prox_status_q,
  input wire logic [15:0] light_hyst_codes_q
);
  // Single domain, so one clock and one disable for all
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_hyst_reset: assert property ($rose(aresetn) |=> light_hyst_codes_q == 16'h0018)
    else $error("hysteresis not 24 codes after reset");
  a_hyst_write: assert property ($changed(light_hyst_codes_q) && $past(aresetn, 2)
    |-> $past(s_axi_bvalid)) else $error("hysteresis moved without a write");
  a_range_write: assert property ($changed(vis_high_range_q) |-> $past(s_axi_bvalid))
    else $error("range moved without a write");
  a_ir_follow: assert property (ir_high_range_q == (LEGACY_SEQ && vis_high_range_q))
    else $error("infrared range wrong for sequencer");
  a_light_sample: assert property ($changed(light_status_q)
    |-> $past(light_in.valid, 2) && !$past(light_in.is_ir, 2))
    else $error("light status moved without a visible sample");
  a_prox_sample: assert property ($changed(prox_status_q)
    |-> $past(prox_in.valid, 2) && $past(prox_in.channel, 2) != 2'h3)
    else $error("proximity status moved without a sample");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule

bind lpt_filter lpt_filter_monitor #(.LEGACY_SEQ(LEGACY_SEQ)) i_mon (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .light_in, .prox_in, .vis_high_range_q,
  .ir_high_range_q, .light_status_q, .prox_status_q, .light_hyst_codes_q);

// [dv/light_prox_threshold_filter_bench.sv]
// Self-checking bench for the threshold filter against a queue-free model.
// Assumes the host model and the monitor bind are compiled with it.
`timescale 1ns/1ps
module light_prox_threshold_filter_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, vis_q, ir_q;
  lpt_pkg::lpt_light_sample_t light_in = '0;
  lpt_pkg::lpt_prox_sample_t prox_in = '0;
  lpt_pkg::lpt_thresholds_t thr_in = {16'h01F4, 16'h0BB8, 16'h0BB8, 16'h07D0, 16'h03E8};
  logic [1:0] light_st;
  logic [2:0] prox_st;
  logic [15:0] lh_codes, ph_codes;
  // Model: byte addresses, register copies, per-channel state and run
  logic [7:0] adr[5] = '{8'h48, 8'h58, 8'h5C, 8'h60, 8'h64};
  logic [7:0] rst[5] = '{8'h00, 8'h48, 8'h48, 8'h03, 8'h03};
  logic [7:0] pv[5] = '{8'h00, 8'h03, 8'h07, 8'hFF, 8'h0F};
  logic [7:0] mdl[5];
  int th[5] = '{1000, 2000, 3000, 3000, 500};
  int st[5], run[5];
  int n_fail = 0;
  int samples_checked = 0;

  always #4 aclk = ~aclk;

  lpt_host_model host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  lpt_filter i_lpt_filter (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .light_in, .prox_in, .thr_in, .vis_high_range_q(vis_q), .ir_high_range_q(ir_q),
    .light_status_q(light_st), .prox_status_q(prox_st), .light_hyst_codes_q(lh_codes),
    .prox_hyst_codes_q(ph_codes));

  task automatic stop_test();
    $display("Compared %0d, mismatched %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t ns: seen %0h, expected %0h", $time, seen, exp);
    end
  endtask

  // Run length is the unbroken ones from bit 0; zero still means one
  function automatic int need(logic [7:0] p);
    int n;
    n = 0;
    while (n < 8 && p[n]) n++;
    return (n == 0) ? 1 : n;
  endfunction

  function automatic int hyst(logic [7:0] e);
    return (e == 8'h00) ? 0 : ((16 + e[3:0]) << e[7:4]) >> 4;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
    bit to;
    host.wr(a, v, r, to);
    n_fail += to;
    if (to) begin
      stop_test();
    end else begin
      chk(r, er);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit to;
    host.rd(a, d, r, to);
    n_fail += to;
    if (to) begin
      stop_test();
    end else begin
      chk(d, ed);
      chk(r, er);
    end
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    mdl = rst;
    st = '{default: 0};
    run = '{default: 0};
  endtask

  task automatic chk_st();
    chk(light_st, {st[4][0], st[3][0]});
    chk(prox_st, {st[2][0], st[1][0], st[0][0]});
  endtask

  task automatic chk_all();
    for (int i = 0; i < 5; i++) rd(adr[i], mdl[i], 2'h0);
    rd(8'h80, {st[2][0], st[1][0], st[0][0], st[4][0], st[3][0]}, 2'h0);
    chk(lh_codes, hyst(mdl[1]));
    chk(ph_codes, hyst(mdl[2]));
    chk(vis_q, mdl[0][5]);
    chk(ir_q, 1'b0);
    chk_st();
  endtask

  // A miss restarts the run; a full run toggles and starts afresh
  task automatic upd(input int k, input int c, input int h, input logic [7:0] p, input bit lo);
    bit q;
    q = (st[k] != lo) ? (c < th[k] - h) : (c > th[k] + h);
    run[k] = q ? run[k] + 1 : 0;
    if (run[k] >= need(p)) begin
      st[k] = 1 - st[k];
      run[k] = 0;
    end
  endtask

  // Channel 3 of proximity and infrared light samples must be ignored
  task automatic smp();
    int ch;
    int c;
    bit ir;
    ch = $urandom_range(0, 4);
    ir = ($urandom_range(0, 5) == 0);
    c = th[(ch == 4) ? 3 + $urandom_range(0, 1) : ch % 3] + $urandom_range(0, 160) - 80;
    prox_in <= {ch < 4, ch[1:0], c[15:0]};
    light_in <= {ch == 4, ir, c[15:0]};
    if (ch < 3) upd(ch, c, hyst(mdl[2]), mdl[3], 1'b0);
    if (ch == 4 && !ir) begin
      upd(3, c, hyst(mdl[1]), mdl[4], 1'b0);
      upd(4, c, hyst(mdl[1]), mdl[4], 1'b1);
    end
    @(posedge aclk);
  endtask

  initial begin
    void'($urandom(89952));
    do_reset();
    chk_all();
    rd(8'h04, 32'h0, 2'h3);
    wr(8'h80, 8'h3F, 2'h3);
    wr(8'h48, 8'hFF, 2'h0);
    mdl[0] = 8'h20;
    for (int i = 0; i < 5; i++) begin
      mdl[1] = 8'($urandom_range(0, 95));
      mdl[2] = 8'($urandom_range(0, 95));
      mdl[3] = pv[i];
      mdl[4] = pv[4 - i];
      for (int j = 1; j < 5; j++) wr(adr[j], mdl[j], 2'h0);
      // Singles and back-to-back pairs, then status settles
      repeat (60) begin
        repeat ($urandom_range(1, 2)) smp();
        light_in.valid <= 1'b0;
        prox_in.valid <= 1'b0;
        repeat (3) @(posedge aclk);
        chk_st();
      end
      chk_all();
    end
    do_reset();
    chk_all();
    stop_test();
  end
endmodule
